// *** meas_model.sv ***
// behavioural measurement subsystem feeding the stage bank
`timescale 1ns/1ns
module meas_model #(
  parameter int NUM_SRC = stage_pkg::SRC_COUNT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // scaled measurements
  output logic [NUM_SRC-1:0][31:0] meas_value
);
  logic [31:0] base [NUM_SRC];
  logic [31:0] ramp [NUM_SRC];
  logic [31:0] acc [NUM_SRC];
  // distinct start levels, so a wrong source pick shows up
  initial begin
    for (int i = 0; i < NUM_SRC; i++) begin
      base[i] = 32'(i) * 32'h0000_1111;
      ramp[i] = 32'h0000_0000;
      acc[i] = 32'h0000_0000;
      meas_value[i] = base[i];
    end
  end
  // new level and slope of one source, seen from the next edge on
  task set_src(input int idx, input logic [31:0] v, input logic [31:0] r);
    base[idx] <= v;
    ramp[idx] <= r;
  endtask
  // refresh every clock; a slope models a quantity on the move
  always @(posedge core_clk or negedge rst_b) begin
    for (int i = 0; i < NUM_SRC; i++) begin
      acc[i] <= (!rst_b || ramp[i] == 32'h0000_0000) ? 32'h0000_0000 : acc[i] + ramp[i];
      meas_value[i] <= base[i] + acc[i];
    end
  end
endmodule

// *** programmable_stage_bank.sv ***
// bank of programmable protection stages with register port
//
// What this block does
// - ten stages, each one to three inputs
// - over, under and rate-of-change terms
// - trip only after definite delay
// - all stages evaluated every 5 ms
// - latency follows source refresh, one to two cycles
// - stage count one to ten; others hidden
// - each stage needs its own enable
// - enabled stage reports condition and times
// - counted stage without enable reports disabled and zero times; scaled values still read; hidden stages read all zero
// - group switch changes settings without restart
// - phase current sources: RMS, harmonics, angle
// - frequency, thermal, RTD, mA, curve sources
// - settable reset hysteresis, default three percent
// - over mode hits above pick-up level
// - multiplier scales input; scaled value readable
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module programmable_stage_bank #(
  parameter int STAGES = stage_pkg::STAGES_MAX,
  parameter int NUM_SRC = stage_pkg::SRC_COUNT,
  parameter int CYCLE_CLKS = stage_pkg::EVAL_CYCLE_CLKS
) (
  // clock, reset and clock enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // values from the measurement subsystem
  input wire logic [NUM_SRC-1:0][31:0] meas_value,
  // register port
  input wire logic [stage_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // stage outputs
  output logic [STAGES-1:0] stage_start,
  output logic [STAGES-1:0] stage_trip
);
  // tick counter width and short names
  localparam int TICK_W = $clog2(CYCLE_CLKS + 1);
  localparam int T = stage_pkg::TERMS;
  localparam int AW = stage_pkg::ADDR_W;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [stage_pkg::GROUPS-1:0][STAGES-1:0][stage_pkg::WORDS-1:0][31:0] set;
    logic act;
    logic [3:0] count;
    logic [stage_pkg::GRP_W-1:0] group;
    logic [STAGES-1:0] enable;
    logic [31:0] rdata;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
  } bank_state_t;
  bank_state_t st_q, st_d;

  logic [STAGES-1:0] visible;
  logic [STAGES-1:0] active_mask;
  logic [STAGES-1:0] pickup_vec;
  logic [STAGES-1:0][1:0] cond_vec;
  logic [STAGES-1:0][31:0] rem_vec;
  logic [STAGES-1:0][31:0] delay_vec;
  logic [STAGES-1:0][T-1:0] hit_vec;
  logic [STAGES-1:0][T-1:0][31:0] scaled_vec;
  logic [31:0] rd_val;

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // stage count is held within one to the number of stages
  function automatic logic [3:0] clamp_count(input logic [3:0] v);
    logic [3:0] r;
    r = v;
    if (v == 4'h0) begin
      r = 4'h1;
    end else if (v > 4'(STAGES)) begin
      r = 4'(STAGES);
    end
    return r;
  endfunction

  // settings page: stage and word inside range
  function automatic logic set_hit(input logic [AW-1:0] a);
    logic [stage_pkg::A_STG_W-1:0] s;
    logic [stage_pkg::A_WRD_W-1:0] w;
    s = a[stage_pkg::A_STG_LSB +: stage_pkg::A_STG_W];
    w = a[stage_pkg::A_WRD_W-1:0];
    return !a[stage_pkg::A_PAGE_BIT] && (32'(s) < STAGES) && (32'(w) < stage_pkg::WORDS);
  endfunction

  // field pickers of a settings address
  function automatic logic [stage_pkg::A_STG_W-1:0] set_stage(input logic [AW-1:0] a);
    return a[stage_pkg::A_STG_LSB +: stage_pkg::A_STG_W];
  endfunction

  function automatic logic [stage_pkg::A_WRD_W-1:0] set_word(input logic [AW-1:0] a);
    return a[stage_pkg::A_WRD_W-1:0];
  endfunction

  function automatic logic [stage_pkg::GRP_W-1:0] set_group(input logic [AW-1:0] a);
    return a[stage_pkg::A_GRP_BIT +: stage_pkg::GRP_W];
  endfunction

  // global page: register index
  function automatic logic glob_hit(input logic [AW-1:0] a, input int idx);
    return a[stage_pkg::A_PAGE_BIT] && !a[stage_pkg::A_STAT_BIT] && (a[stage_pkg::A_SSTG_LSB-1:0] == 3'(idx))
      && (a[stage_pkg::A_STAT_BIT-1:stage_pkg::A_SSTG_LSB] == '0);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // stage visibility and enables

  // only the first count stages exist while the function is activated
  always_comb begin
    for (int s = 0; s < STAGES; s++) begin
      visible[s] = st_q.act && (4'(s) < st_q.count);
      active_mask[s] = visible[s] && st_q.enable[s];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stages: terms and timers

  generate
    for (genvar s = 0; s < STAGES; s++) begin : g_stage
      logic [31:0] cfg;
      logic [1:0] nterm;
      // live group selects the settings each cycle
      assign cfg = st_q.set[st_q.group][s][stage_pkg::W_CFG];
      assign delay_vec[s] = st_q.set[st_q.group][s][stage_pkg::W_DELAY];
      // a term count of zero means one term
      assign nterm = (cfg[stage_pkg::CFG_CNT_LSB +: stage_pkg::CFG_CNT_W] == 2'h0) ? 2'h1
        : cfg[stage_pkg::CFG_CNT_LSB +: stage_pkg::CFG_CNT_W];
      for (genvar t = 0; t < T; t++) begin : g_term
        logic [stage_pkg::SRC_W-1:0] src;
        logic [31:0] sample;
        // source index of this term
        assign src = cfg[stage_pkg::CFG_SRC_LSB + t * stage_pkg::SRC_W +: stage_pkg::SRC_W];
        // latest value of the chosen source is taken at each tick
        assign sample = (32'(src) < NUM_SRC) ? meas_value[src] : '0;
        // unused terms never hit
        stage_compare u_cmp (
          .core_clk(core_clk),
          .rst_b(rst_b),
          .ce(ce),
          .tick(st_q.tick),
          .used(2'(t) < nterm),
          .mode(cfg[stage_pkg::CFG_MODE_LSB + 2 * t +: 2]),
          .sample(sample),
          .mult(st_q.set[st_q.group][s][stage_pkg::W_MULT + t]),
          .level(st_q.set[st_q.group][s][stage_pkg::W_LEVEL + t]),
          .hyst(st_q.set[st_q.group][s][stage_pkg::W_HYST + t]),
          .scaled(scaled_vec[s][t]),
          .hit(hit_vec[s][t])
        );
      end
      // any satisfied term picks the stage up
      assign pickup_vec[s] = |hit_vec[s];
      // delay and condition of the stage
      stage_timer u_tmr (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(st_q.tick),
        .active(active_mask[s]),
        .pickup(pickup_vec[s]),
        .delay(delay_vec[s]),
        .cond(cond_vec[s]),
        .remaining(rem_vec[s]),
        .trip(stage_trip[s])
      );
      // start decoded from the timer state
      assign stage_start[s] = (cond_vec[s] == stage_pkg::COND_START);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read data selection

  always_comb begin
    logic [stage_pkg::A_STG_W-1:0] ss;
    logic [stage_pkg::A_SWRD_W-1:0] sw;
    ss = reg_addr[stage_pkg::A_SSTG_LSB +: stage_pkg::A_STG_W];
    sw = reg_addr[stage_pkg::A_SWRD_W-1:0];
    rd_val = '0;
    if (set_hit(reg_addr)) begin
      // settings read back as written
      rd_val = st_q.set[set_group(reg_addr)][set_stage(reg_addr)][set_word(reg_addr)];
    end else if (glob_hit(reg_addr, stage_pkg::G_CTRL)) begin
      // control word: activation, count, group
      rd_val[stage_pkg::CTRL_ACT_BIT] = st_q.act;
      rd_val[stage_pkg::CTRL_CNT_LSB +: 4] = st_q.count;
      rd_val[stage_pkg::CTRL_GRP_BIT +: stage_pkg::GRP_W] = st_q.group;
    end else if (glob_hit(reg_addr, stage_pkg::G_ENABLE)) begin
      rd_val[STAGES-1:0] = st_q.enable;
    end else if (reg_addr[stage_pkg::A_PAGE_BIT] && reg_addr[stage_pkg::A_STAT_BIT] && (32'(ss) < STAGES)) begin
      // hidden stages read as zero; disabled ones carry no timing
      if (visible[ss]) begin
        case (sw)
          3'(stage_pkg::S_COND): begin
            rd_val[1:0] = active_mask[ss] ? cond_vec[ss] : 2'(stage_pkg::COND_DISABLED);
            if (active_mask[ss] && cond_vec[ss] == stage_pkg::COND_DISABLED) begin
              rd_val[1:0] = 2'(stage_pkg::COND_NORMAL);
            end
          end
          3'(stage_pkg::S_EXPECT): rd_val = active_mask[ss] ? delay_vec[ss] : '0;
          3'(stage_pkg::S_REMAIN): rd_val = active_mask[ss] ? rem_vec[ss] : '0;
          3'(stage_pkg::S_SCALED): rd_val = scaled_vec[ss][0];
          3'(stage_pkg::S_SCALED + 1): rd_val = scaled_vec[ss][1];
          3'(stage_pkg::S_SCALED + 2): rd_val = scaled_vec[ss][2];
          default: rd_val = '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: tick, register writes, read capture

  always_comb begin
    st_d = st_q;
    if (ce) begin
      // evaluation tick every 5 ms
      if (st_q.tick_cnt == TICK_W'(CYCLE_CLKS - 1)) begin
        st_d.tick_cnt = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.tick_cnt = st_q.tick_cnt + TICK_W'(1);
        st_d.tick = 1'b0;
      end
      // writes land at the next edge
      if (reg_wr) begin
        if (set_hit(reg_addr)) begin
          st_d.set[set_group(reg_addr)][set_stage(reg_addr)][set_word(reg_addr)] = reg_wdata;
        end else if (glob_hit(reg_addr, stage_pkg::G_CTRL)) begin
          // control word fields
          st_d.act = reg_wdata[stage_pkg::CTRL_ACT_BIT];
          st_d.count = clamp_count(reg_wdata[stage_pkg::CTRL_CNT_LSB +: 4]);
          st_d.group = reg_wdata[stage_pkg::CTRL_GRP_BIT +: stage_pkg::GRP_W];
        end else if (glob_hit(reg_addr, stage_pkg::G_ENABLE)) begin
          st_d.enable = reg_wdata[STAGES-1:0];
        end
      end
      // read data stands one cycle
      st_d.rdata = reg_rd ? rd_val : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      // inactive, one stage, group zero
      st_q.count <= stage_pkg::RST_COUNT;
      for (int g = 0; g < stage_pkg::GROUPS; g++) begin
        for (int s = 0; s < STAGES; s++) begin
          // both groups start at defaults
          st_q.set[g][s][stage_pkg::W_CFG] <= stage_pkg::RST_CFG;
          st_q.set[g][s][stage_pkg::W_DELAY] <= stage_pkg::RST_DELAY;
          for (int t = 0; t < T; t++) begin
            st_q.set[g][s][stage_pkg::W_MULT + t] <= stage_pkg::RST_MULT;
            st_q.set[g][s][stage_pkg::W_LEVEL + t] <= stage_pkg::RST_LEVEL;
            st_q.set[g][s][stage_pkg::W_HYST + t] <= stage_pkg::RST_HYST;
          end
        end
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  // status addresses watched below
  localparam logic [AW-1:0] STAT_BASE = AW'(1 << stage_pkg::A_PAGE_BIT) | AW'(1 << stage_pkg::A_STAT_BIT);
  localparam logic [AW-1:0] LAST_COND_A = STAT_BASE | AW'((STAGES - 1) << stage_pkg::A_SSTG_LSB);
  localparam logic [AW-1:0] S0_EXP_A = STAT_BASE | AW'(stage_pkg::S_EXPECT);
  localparam logic [AW-1:0] S0_REM_A = STAT_BASE | AW'(stage_pkg::S_REMAIN);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // a trip needs an enabled stage
  a_trip_needs_enable: assert property ((stage_trip & ~$past(active_mask)) == '0)
    else $error("trip on a stage that was not enabled");

  // evaluation tick spacing
  a_tick_period: assert property ($rose(st_q.tick) |-> $past(st_q.tick_cnt) == TICK_W'(CYCLE_CLKS - 1))
    else $error("evaluation tick off period");

  // enable low holds the tick and the stages
  a_ce_freeze: assert property (!ce |=> $stable(st_q.tick_cnt) && $stable(cond_vec))
    else $error("state moved while clock enable low");

  // hidden stages read as zero
  a_hidden_read: assert property (reg_rd && ce && reg_addr == LAST_COND_A && st_q.count < 4'(STAGES)
    |=> reg_rdata == '0) else $error("hidden stage status not zero");

  // inactive stage shows no timing
  a_disabled_read: assert property (reg_rd && ce && reg_addr == S0_EXP_A && !active_mask[0] |=> reg_rdata == '0)
    else $error("inactive stage shows timing");

  // active stage reports its times
  a_remain_read: assert property (reg_rd && ce && reg_addr == S0_REM_A && active_mask[0]
    |=> reg_rdata == $past(rem_vec[0])) else $error("remaining time read wrong");
  a_expect_read: assert property (reg_rd && ce && reg_addr == S0_EXP_A && active_mask[0]
    |=> reg_rdata == $past(delay_vec[0])) else $error("expected time read wrong");

  // read data stands one cycle only
  a_rdata_one_cycle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  // trip follows a counted start
  a_trip_after_delay: assert property ($rose(stage_trip[0]) |-> $past(cond_vec[0]) == stage_pkg::COND_START)
    else $error("trip without a counted start");
  a_start_trip_apart: assert property ((stage_start & stage_trip) == '0)
    else $error("start and trip at once");

  // trip moves only at a tick or on deactivation
  a_trip_steps: assert property ($changed(stage_trip[1]) |-> $past(st_q.tick) || !$past(active_mask[1]))
    else $error("trip moved outside a tick");

  // countdown abandoned when pick-up clears
  a_abandon_count: assert property (ce && st_q.tick && active_mask[1] && cond_vec[1] == stage_pkg::COND_START
    && !pickup_vec[1] |=> cond_vec[1] == stage_pkg::COND_NORMAL && !stage_trip[1])
    else $error("countdown not abandoned");

  // conditions move only on ticks or on deactivation
  a_group_no_restart: assert property ($changed(cond_vec[0]) |-> ($past(st_q.tick) && $past(ce))
    || !$past(active_mask[0])) else $error("condition moved outside a tick");

  // main scenarios
  c_trip: cover property ($rose(stage_trip[0]));
  c_abandon: cover property (st_q.tick && cond_vec[1] == stage_pkg::COND_START && !pickup_vec[1]);
  c_group_live: cover property ($changed(st_q.group) && cond_vec[0] == stage_pkg::COND_START);
  c_roc_trip: cover property ($rose(stage_trip[2]));
  c_freeze: cover property (!ce && reg_wr);
endmodule

// *** stage_compare.sv ***
// one pick-up term: scaling, mode compare and reset hysteresis
`timescale 1ns/1ns
module stage_compare (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // evaluation inputs
  input wire logic tick,
  input wire logic used,
  input wire logic [1:0] mode,
  input wire logic [31:0] sample,
  input wire logic [31:0] mult,
  input wire logic [31:0] level,
  input wire logic [31:0] hyst,
  // results
  output logic [31:0] scaled,
  output logic hit
);
  typedef struct packed {
    logic [31:0] scaled;
    logic primed;
    logic hit;
  } cmp_state_t;
  cmp_state_t q, d;
  logic signed [63:0] prod;
  logic signed [63:0] hprod;
  logic signed [32:0] val;
  logic signed [32:0] lvl;
  logic signed [32:0] hy;
  logic [31:0] nscaled;

  // scale the sample, form the compared value, apply hysteresis
  always_comb begin
    prod = $signed(sample) * $signed(mult);
    nscaled = prod[stage_pkg::FRAC_W +: 32];
    hprod = $signed(level) * $signed({1'b0, hyst[30:0]});
    hy = 33'($signed(hprod[stage_pkg::FRAC_W +: 32]));
    lvl = 33'($signed(level));
    val = 33'($signed(nscaled));
    if (mode == stage_pkg::MODE_ROC) begin
      val = 33'($signed(nscaled)) - 33'($signed(q.scaled));
    end
    d = q;
    if (ce && tick) begin
      d.scaled = nscaled;
      d.primed = 1'b1;
      case (mode)
        stage_pkg::MODE_OVER: d.hit = q.hit ? (val > lvl - hy) : (val > lvl);
        stage_pkg::MODE_UNDER: d.hit = q.hit ? (val < lvl + hy) : (val < lvl);
        stage_pkg::MODE_ROC: d.hit = q.primed && (q.hit ? (val > lvl - hy) : (val > lvl));
        default: d.hit = 1'b0;
      endcase
      if (!used) begin
        d.hit = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign scaled = q.scaled;
  assign hit = q.hit;
endmodule

// *** stage_pkg.sv ***
// shared constants and types for the programmable stage bank
package stage_pkg;
  // evaluation timing
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int EVAL_CYCLE_US = 5000;
  localparam int EVAL_CYCLE_CLKS = (EVAL_CYCLE_US * CLK_FREQ_KHZ) / 1000;
  localparam int DELAY_DEF_US = 40000;
  localparam int DELAY_DEF_TICKS = DELAY_DEF_US / EVAL_CYCLE_US;
  // bank dimensions
  localparam int STAGES_MAX = 10;
  localparam int TERMS = 3;
  localparam int GROUPS = 2;
  localparam int GRP_W = 1;
  localparam int FRAC_W = 16;
  // term modes and stage conditions
  typedef enum logic [1:0] {MODE_OVER, MODE_UNDER, MODE_ROC} term_mode_t;
  typedef enum logic [1:0] {COND_DISABLED, COND_NORMAL, COND_START, COND_TRIP} cond_t;
  // source index map: five current channels of sixteen slots each
  localparam int SRC_CH_STRIDE = 16;
  localparam int SRC_FUND = 0;
  localparam int SRC_HARM_FIRST = 1;
  localparam int SRC_TRMS = 12;
  localparam int SRC_ANGLE = 13;
  localparam int SRC_SYS_FREQ = 80;
  localparam int SRC_REF_FREQ = 81;
  localparam int SRC_THERMAL = 83;
  localparam int SRC_RTD = 86;
  localparam int SRC_EXT_RTD = 102;
  localparam int SRC_MA_IN = 110;
  localparam int SRC_CURVE = 114;
  localparam int SRC_COUNT = 118;
  // register address fields
  localparam int ADDR_W = 12;
  localparam int A_PAGE_BIT = 11;
  localparam int A_STAT_BIT = 10;
  localparam int A_GRP_BIT = 8;
  localparam int A_STG_LSB = 4;
  localparam int A_STG_W = 4;
  localparam int A_WRD_W = 4;
  localparam int A_SSTG_LSB = 3;
  localparam int A_SWRD_W = 3;
  // setting words of one stage
  localparam int W_CFG = 0;
  localparam int W_DELAY = 1;
  localparam int W_MULT = 2;
  localparam int W_LEVEL = 5;
  localparam int W_HYST = 8;
  localparam int WORDS = 11;
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_CNT_W = 2;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_SRC_LSB = 8;
  localparam int SRC_W = 8;
  // global and status words
  localparam int G_CTRL = 0;
  localparam int G_ENABLE = 1;
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_CNT_LSB = 1;
  localparam int CTRL_GRP_BIT = 8;
  localparam int S_COND = 0;
  localparam int S_EXPECT = 1;
  localparam int S_REMAIN = 2;
  localparam int S_SCALED = 3;
  // reset values
  localparam logic [31:0] RST_CFG = 32'h0000_0001;
  localparam logic [31:0] RST_DELAY = 32'(DELAY_DEF_TICKS);
  localparam logic [31:0] RST_MULT = 32'h0001_0000;
  localparam logic [31:0] RST_LEVEL = 32'h0000_028F;
  localparam logic [31:0] RST_HYST = 32'h0000_07AE;
  localparam logic [3:0] RST_COUNT = 4'h1;
endpackage

// *** stage_timer.sv ***
// definite-time delay and condition tracking for one stage
`timescale 1ns/1ns
module stage_timer (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // evaluation inputs
  input wire logic tick,
  input wire logic active,
  input wire logic pickup,
  input wire logic [31:0] delay,
  // status
  output logic [1:0] cond,
  output logic [31:0] remaining,
  output logic trip
);
  typedef struct packed {
    stage_pkg::cond_t cond;
    logic [31:0] rem;
    logic trip;
  } timer_state_t;
  timer_state_t q, d;

  // condition machine, stepped once per evaluation tick
  always_comb begin
    d = q;
    if (ce) begin
      if (!active) begin
        d = '0;
      end else if (tick) begin
        case (q.cond)
          stage_pkg::COND_DISABLED, stage_pkg::COND_NORMAL: begin
            d.cond = pickup ? stage_pkg::COND_START : stage_pkg::COND_NORMAL;
            d.rem = pickup ? delay : '0;
          end
          stage_pkg::COND_START: begin
            if (!pickup) begin
              d.cond = stage_pkg::COND_NORMAL;
              d.rem = '0;
            end else if (q.rem <= 32'h0000_0001) begin
              d.cond = stage_pkg::COND_TRIP;
              d.rem = '0;
              d.trip = 1'b1;
            end else begin
              d.rem = q.rem - 32'h0000_0001;
            end
          end
          stage_pkg::COND_TRIP: begin
            if (!pickup) begin
              d.cond = stage_pkg::COND_NORMAL;
              d.trip = 1'b0;
            end
          end
          default: d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cond = q.cond;
  assign remaining = q.rem;
  assign trip = q.trip;
endmodule

// *** tb_programmable_stage_bank.sv ***
// self-checking bench for the programmable stage bank
`timescale 1ns/1ns
module tb_programmable_stage_bank;
  localparam int CYC = 20;
  localparam int NS = stage_pkg::SRC_COUNT;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [NS-1:0][31:0] meas_value;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [9:0] stage_start;
  logic [9:0] stage_trip;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rv;
  logic [31:0] m;
  logic [11:0] da [5];
  logic [31:0] de [5];

  ////////////////////////////////////////////////////////////////////////
  // clock and cycle count
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  meas_model #(.NUM_SRC(NS)) pm (.core_clk(core_clk), .rst_b(rst_b), .meas_value(meas_value));
  programmable_stage_bank #(.STAGES(10), .NUM_SRC(NS), .CYCLE_CLKS(CYC)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .meas_value(meas_value),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stage_start(stage_start), .stage_trip(stage_trip));

  ////////////////////////////////////////////////////////////////////////
  // verdict, compare and bus tasks
  task wrap_up;
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(nm, e, rv);
  endtask
  function automatic logic [11:0] sa(int g, int s, int w);
    return 12'((g << 8) | (s << 4) | w);
  endfunction
  function automatic logic [11:0] st(int s, int w);
    return 12'(32'h0000_0C00 | (s << 3) | w);
  endfunction
  // bounded wait for a start or trip line to reach a level
  task wait_o(input int trp, input int s, input logic lv, input int lim);
    for (int n = 0; n <= lim; n++) begin
      @(posedge core_clk);
      #1;
      if ((trp != 0 ? stage_trip[s] : stage_start[s]) === lv) return;
    end
    chk("wait", 32'h1, 32'h0);
    wrap_up;
  endtask
  task arm(input int s, input int md, input int src, input logic [31:0] lvl, input int d);
    wr(sa(0, s, stage_pkg::W_CFG), 32'((src << 8) | (md << 2) | 1));
    wr(sa(0, s, stage_pkg::W_LEVEL), lvl);
    wr(sa(0, s, stage_pkg::W_DELAY), 32'(d));
  endtask
  // start, then trip after exactly d evaluation ticks
  task trip_time(input int s, input int d);
    wait_o(0, s, 1'b1, 4 * CYC);
    t0 = cyc;
    rchk("expect", st(s, stage_pkg::S_EXPECT), 32'(d));
    rchk("remain", st(s, stage_pkg::S_REMAIN), 32'(d));
    wait_o(1, s, 1'b1, (d + 1) * CYC);
    chk("trip delay", 32'(d * CYC), 32'(cyc - t0));
    rchk("cond trip", st(s, stage_pkg::S_COND), 32'h0000_0003);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h03504c07));
    da = '{sa(0, 0, 0), sa(0, 0, 1), sa(0, 0, 2), sa(0, 0, 5), sa(1, 9, 10)};
    de = '{stage_pkg::RST_CFG, stage_pkg::RST_DELAY, stage_pkg::RST_MULT, stage_pkg::RST_LEVEL,
           stage_pkg::RST_HYST};
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) rchk("default", da[i], de[i]);
    rchk("unmapped", 12'h8F0, 32'h0000_0000);
    rchk("unmapped", 12'hBFF, 32'h0000_0000);
    // enable low: a write is ignored
    ce <= 1'b0;
    wr(sa(0, 9, stage_pkg::W_DELAY), 32'h0000_0005);
    ce <= 1'b1;
    rchk("frozen write", sa(0, 9, stage_pkg::W_DELAY), stage_pkg::RST_DELAY);
    rchk("cond off", st(0, stage_pkg::S_COND), 32'h0000_0000);
    m = $urandom;
    wr(sa(1, 4, stage_pkg::W_LEVEL), m);
    rchk("group1 level", sa(1, 4, stage_pkg::W_LEVEL), m);
    pm.set_src(stage_pkg::SRC_TRMS, 32'h0, 32'h0);
    arm(0, stage_pkg::MODE_OVER, stage_pkg::SRC_TRMS, 32'h0001_0000, 3);
    wr(sa(0, 0, stage_pkg::W_MULT), 32'h0002_0000);
    arm(1, stage_pkg::MODE_UNDER, stage_pkg::SRC_SYS_FREQ, 32'h0001_0000, 4);
    arm(2, stage_pkg::MODE_ROC, stage_pkg::SRC_MA_IN, 32'h0000_1000, 2);
    arm(3, stage_pkg::MODE_OVER, stage_pkg::SRC_CURVE, 32'h0001_0000, 1);
    arm(5, stage_pkg::MODE_OVER, stage_pkg::SRC_CURVE, 32'h0001_0000, 1);
    wr(12'h800, 32'h0000_0009);
    wr(12'h801, 32'h0000_0027);
    repeat (3 * CYC) @(posedge core_clk);
    #1 chk("idle trips", 32'h0, 32'(stage_trip));
    rchk("not enabled", st(3, stage_pkg::S_COND), 32'h0000_0000);
    rchk("no timing", st(3, stage_pkg::S_EXPECT), 32'h0000_0000);
    rchk("not counted", st(5, stage_pkg::S_COND), 32'h0000_0000);
    rchk("normal", st(0, stage_pkg::S_COND), 32'h0000_0001);
    // over term through the multiplier
    m = 32'h0001_8000 + ($urandom & 32'h0000_7FFF);
    pm.set_src(stage_pkg::SRC_TRMS, m, 32'h0);
    trip_time(0, 3);
    rchk("scaled", st(0, stage_pkg::S_SCALED), 32'((longint'(m) * 64'h2_0000) >>> 16));
    // switch group while running: new level clears the trip
    wr(sa(1, 0, stage_pkg::W_CFG), 32'((stage_pkg::SRC_TRMS << 8) | 1));
    wr(sa(1, 0, stage_pkg::W_LEVEL), 32'h7FFF_0000);
    wr(12'h800, 32'h0000_0109);
    wait_o(1, 0, 1'b0, 3 * CYC);
    rchk("cond group", st(0, stage_pkg::S_COND), 32'h0000_0001);
    pm.set_src(stage_pkg::SRC_TRMS, 32'h0, 32'h0);
    wr(12'h800, 32'h0000_0009);
    // pick-up lost in mid countdown
    pm.set_src(stage_pkg::SRC_SYS_FREQ, 32'h0000_8000, 32'h0);
    wait_o(0, 1, 1'b1, 4 * CYC);
    repeat (2 * CYC) @(posedge core_clk);
    pm.set_src(stage_pkg::SRC_SYS_FREQ, 32'h0002_0000, 32'h0);
    wait_o(0, 1, 1'b0, 2 * CYC);
    repeat (6 * CYC) @(posedge core_clk);
    #1 chk("no trip", 32'h0, 32'(stage_trip[1]));
    // under and rate-of-change terms
    wr(sa(0, 1, stage_pkg::W_DELAY), 32'h0000_0001);
    pm.set_src(stage_pkg::SRC_SYS_FREQ, 32'h0000_8000, 32'h0);
    trip_time(1, 1);
    pm.set_src(stage_pkg::SRC_MA_IN, 32'h0, 32'h0000_0100);
    trip_time(2, 2);
    // deactivating the bank drops trips and timing words
    wr(12'h800, 32'h0000_0000);
    wait_o(1, 2, 1'b0, 2);
    rchk("off cond", st(2, stage_pkg::S_COND), 32'h0000_0000);
    rchk("off expect", st(2, stage_pkg::S_EXPECT), 32'h0000_0000);
    wrap_up;
  end
endmodule
